// ### hdl/clkrst_pkg.sv
// Purpose: Constants for the clock source and reset sequencer
// Assumes: Core clock of 125 MHz; I/O register addresses are 8 bits
// Notes:   Timing counts derive from times in their own unit
package clkrst_pkg;

	localparam int CLK_MHZ = 125;

	// I/O register addresses
	localparam logic [7:0] ADDR_PORT2     = 8'h02;
	localparam logic [7:0] ADDR_WD_RESTART = 8'h26;
	localparam logic [7:0] ADDR_CLK_CFG   = 8'hf8;
	localparam logic [7:0] ADDR_STATUS    = 8'hff;

	// Clock configuration fields
	localparam int CFG_EXT_OSC_EN   = 0;
	localparam int CFG_CLKOUT_DIS   = 1;
	localparam int CFG_LVR_DIS      = 3;
	localparam int CFG_RESUME_DELAY = 7;
	localparam logic [7:0] CFG_RESET = 8'h00;

	// Status and control fields
	localparam int ST_RUN      = 0;
	localparam int ST_SUSPEND  = 3;
	localparam int ST_LV_FLAG  = 4;
	localparam int ST_WD_FLAG  = 6;
	localparam logic [7:0] ST_POWERUP  = 8'h11;
	localparam logic [7:0] ST_WATCHDOG = 8'h41;

	// Auxiliary port fields
	localparam int AUX_IN1 = 1;
	localparam int AUX_IN2 = 2;

	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam logic [7:0]  STACK_RESET  = 8'h00;

	// Times
	localparam int SHORT_DELAY_US  = 128;
	localparam int LONG_DELAY_MS   = 4;
	localparam int STARTUP_MS      = 24;
	localparam int WATCHDOG_MS     = 10;
	localparam int WD_RESET_MS     = 2;
	localparam int WAKE_DELAY_US   = 8;

	// Cycle counts: least times round up
	localparam int SHORT_DELAY_CYC = SHORT_DELAY_US * CLK_MHZ;
	localparam int LONG_DELAY_CYC  = LONG_DELAY_MS * 1000 * CLK_MHZ;
	localparam int STARTUP_CYC     = STARTUP_MS * 1000 * CLK_MHZ;
	localparam int WATCHDOG_CYC    = WATCHDOG_MS * 1000 * CLK_MHZ;
	localparam int WD_RESET_CYC    = WD_RESET_MS * 1000 * CLK_MHZ;
	localparam int WAKE_DELAY_CYC  = WAKE_DELAY_US * CLK_MHZ;

	typedef enum logic [2:0] {
		ST_HOLD_LOW  = 3'b000,
		ST_STARTUP   = 3'b001,
		ST_RUNNING   = 3'b010,
		ST_OSC_START = 3'b011,
		ST_RESUME    = 3'b100,
		ST_WD_HOLD   = 3'b101,
		ST_SUSPENDED = 3'b110,
		ST_WAKE      = 3'b111
	} seq_state_t;

endpackage : clkrst_pkg

// ### hdl/clock_reset_controller.sv
// Purpose: Clock source switching and reset sequencing
// Assumes: Analog monitors and oscillator ready arrive as asynchronous levels
// Notes:   Summary of operation follows
// Summary of operation
// - Power up on internal 6 MHz oscillator
// - Internal clock out unless output disabled
// - Oscillator input readable, pulled down, no interrupt
// - Enable bit halts, swaps oscillators
// - Stable external clock re-enables clock tree
// - Resume delay 128 us or 4 ms
// - Return to internal only on suspend wake or supply reset
// - Record reset cause in status bits
// - Restart at zero without pushing state
// - Reset clears registers, tristates pins, disables interrupts
// - Supply reset selects internal, waits 24 ms
// - Watchdog keeps clock mode, clears enable
// - Stack pointers reset to zero
// - Power-up holds until supply good, times out
// - Low-voltage reset repeats, disable bit, suspend
// - Brown-out active when low-voltage reset off
// - Restart write clears watchdog, else reset
// - Watchdog status 010X0001, hold 2 ms
// - Suspend stops oscillators and timers
// - Internal wake waits 8 us
`timescale 1ns/10ps
module clock_reset_controller
	import clkrst_pkg::*;
#(
	parameter int SHORT_DELAY = SHORT_DELAY_CYC,
	parameter int LONG_DELAY  = LONG_DELAY_CYC,
	parameter int STARTUP     = STARTUP_CYC,
	parameter int WATCHDOG    = WATCHDOG_CYC,
	parameter int WD_RESET    = WD_RESET_CYC,
	parameter int WAKE_DELAY  = WAKE_DELAY_CYC
) (
	// Clock and reset
	input  wire logic       CLK,
	input  wire logic       RESETN,
	// I/O register port
	input  wire logic [7:0] IO_ADDR,
	input  wire logic [7:0] IO_WDATA,
	input  wire logic       IO_WR,
	input  wire logic       IO_RD,
	output logic      [7:0] IO_RDATA,
	// Wake request from suspend
	input  wire logic       WAKE_EVENT,
	// Analog monitors and oscillator
	input  wire logic       SUPPLY_ABOVE_LVR,
	input  wire logic       SUPPLY_ABOVE_BOR,
	input  wire logic       EXT_OSC_STABLE,
	output logic            INT_OSC_ON,
	output logic            EXT_OSC_ON,
	output logic            CLK_SEL_EXT,
	output logic            CORE_CLK_EN,
	output logic            LVR_ACTIVE,
	output logic            BOR_ACTIVE,
	// Oscillator pins
	input  wire logic       OSC_IN_PIN_I,
	output logic            OSC_IN_PULLDOWN,
	input  wire logic       OSC_OUT_PIN_I,
	output logic            OSC_OUT_PIN_O,
	output logic            OSC_OUT_PIN_OE_N,
	// Processor reset controls
	output logic            CPU_RESET,
	output logic            CPU_RUN,
	output logic     [15:0] RESET_PC,
	output logic      [7:0] PSP_RESET,
	output logic      [7:0] DSP_RESET,
	output logic            NO_STACK_PUSH,
	output logic            PINS_HIZ,
	output logic            IRQ_DISABLE,
	output logic            USB_DISABLE
);
	seq_state_t state, next_state;
	logic       rst_s1, rst_n;
	logic [3:0] s1, s2;
	logic       lvr_ok, bor_ok, osc_ok, wake;
	logic [7:0] cfg, status;
	logic       ext_mode, int_clk_div;
	logic [31:0] load_value;
	logic       load, done, run_timer;
	logic [31:0] wd_count;
	logic       wd_bite;

	// Reset release through two flops
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	// Asynchronous levels synchronised before use
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= 4'h0;
			s2 <= 4'h0;
		end else begin
			s1 <= {WAKE_EVENT, EXT_OSC_STABLE, SUPPLY_ABOVE_BOR, SUPPLY_ABOVE_LVR};
			s2 <= s1;
		end
	end
	assign lvr_ok = s2[0];
	assign bor_ok = s2[1];
	assign osc_ok = s2[2];
	assign wake   = s2[3];

	logic [1:0] aux_s1, aux_s2;
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			aux_s1 <= 2'b00;
			aux_s2 <= 2'b00;
		end else begin
			aux_s1 <= {OSC_OUT_PIN_I, OSC_IN_PIN_I};
			aux_s2 <= aux_s1;
		end
	end

	// Monitor selection
	wire in_suspend  = (state == ST_SUSPENDED);
	wire lvr_enabled = !cfg[CFG_LVR_DIS] && !in_suspend;
	wire lvr_trip    = lvr_enabled && !lvr_ok;
	wire bor_trip    = !lvr_enabled && !bor_ok;
	wire supply_trip = lvr_trip || bor_trip;

	// Register decode
	wire wr_cfg     = IO_WR && IO_ADDR == ADDR_CLK_CFG;
	wire wr_status  = IO_WR && IO_ADDR == ADDR_STATUS;
	wire wr_wd      = IO_WR && IO_ADDR == ADDR_WD_RESTART;
	wire cpu_active = (state == ST_RUNNING);
	wire ext_req    = cpu_active && wr_cfg && IO_WDATA[CFG_EXT_OSC_EN] && !ext_mode;
	wire susp_req   = cpu_active && wr_status && IO_WDATA[ST_SUSPEND] && IO_WDATA[ST_RUN];

	// Watchdog runs only while code executes
	assign wd_bite = cpu_active && (wd_count >= 32'(WATCHDOG - 1));
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			wd_count <= '0;
		else if (!cpu_active || wr_wd)
			wd_count <= '0;
		else
			wd_count <= wd_count + 32'd1;
	end

	// Sequencer
	always_comb begin
		next_state = state;
		load       = 1'b0;
		load_value = '0;
		if (supply_trip) begin
			next_state = ST_HOLD_LOW;
		end else begin
			case (state)
				ST_HOLD_LOW: begin
					if (lvr_ok) begin
						next_state = ST_STARTUP;
						load       = 1'b1;
						load_value = 32'(STARTUP);
					end
				end
				ST_STARTUP:   if (done) next_state = ST_RUNNING;
				ST_RUNNING: begin
					if (wd_bite) begin
						next_state = ST_WD_HOLD;
						load       = 1'b1;
						load_value = 32'(WD_RESET);
					end else if (susp_req) begin
						next_state = ST_SUSPENDED;
					end else if (ext_req) begin
						next_state = ST_OSC_START;
					end
				end
				ST_OSC_START: begin
					if (osc_ok) begin
						next_state = ST_RESUME;
						load       = 1'b1;
						load_value = cfg[CFG_RESUME_DELAY] ? 32'(LONG_DELAY)
						                                   : 32'(SHORT_DELAY);
					end
				end
				ST_RESUME:    if (done) next_state = ST_RUNNING;
				ST_WD_HOLD:   if (done) next_state = ST_RUNNING;
				ST_SUSPENDED: begin
					if (wake) begin
						if (cfg[CFG_EXT_OSC_EN]) begin
							next_state = ST_OSC_START;
						end else begin
							next_state = ST_WAKE;
							load       = 1'b1;
							load_value = 32'(WAKE_DELAY);
						end
					end
				end
				ST_WAKE:      if (done) next_state = ST_RUNNING;
				default:      next_state = ST_HOLD_LOW;
			endcase
		end
	end

	assign run_timer = (state == ST_STARTUP) || (state == ST_RESUME) ||
	                   (state == ST_WD_HOLD) || (state == ST_WAKE);

	interval_timer #(.WIDTH(32)) u_timer (
		.clk   (CLK),
		.rst_n (rst_n),
		.load  (load),
		.value (load_value),
		.run   (run_timer),
		.done  (done)
	);

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			state <= ST_HOLD_LOW;
		else
			state <= next_state;
	end

	// Clock mode: switches to internal only on suspend wake or supply reset
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			ext_mode <= 1'b0;
		else if (state == ST_HOLD_LOW)
			ext_mode <= 1'b0;
		else if (ext_req)
			ext_mode <= 1'b1;
		else if (in_suspend && wake)
			ext_mode <= cfg[CFG_EXT_OSC_EN];
	end

	// Configuration register; a watchdog bite clears only the enable bit
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			cfg <= CFG_RESET;
		else if (state == ST_HOLD_LOW)
			cfg <= CFG_RESET;
		else if (wd_bite)
			cfg[CFG_EXT_OSC_EN] <= 1'b0;
		else if (cpu_active && wr_cfg)
			cfg <= IO_WDATA;
	end

	// Status register is loaded whole with the cause value on supply and watchdog reset
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			status <= ST_POWERUP;
		else if (state == ST_HOLD_LOW)
			status <= ST_POWERUP;
		else if (wd_bite)
			status <= ST_WATCHDOG;
		else if (cpu_active && wr_status)
			status <= {IO_WDATA[7:4], 1'b0, IO_WDATA[2:0]} | 8'h01;
		else if (in_suspend && wake)
			status[ST_SUSPEND] <= 1'b0;
	end

	// Divided core clock shown on the output pin in internal mode, except in suspend, unless output disabled
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			int_clk_div <= 1'b0;
		else
			int_clk_div <= ~int_clk_div;
	end

	wire in_reset  = (state == ST_HOLD_LOW) || (state == ST_STARTUP) ||
	                 (state == ST_WD_HOLD);
	wire osc_int   = !ext_mode && state != ST_OSC_START && !in_suspend;
	wire osc_ext   = (ext_mode || state == ST_OSC_START) && !in_suspend;
	wire drive_out = !ext_mode && !cfg[CFG_CLKOUT_DIS] && osc_int;

	logic [7:0] next_rdata;
	always_comb begin
		next_rdata = 8'h00;
		if (IO_RD) begin
			case (IO_ADDR)
				ADDR_CLK_CFG: next_rdata = cfg;
				ADDR_STATUS:  next_rdata = status;
				ADDR_PORT2: begin
					next_rdata[AUX_IN1] = aux_s2[0] && !ext_mode;
					next_rdata[AUX_IN2] = aux_s2[1] && !drive_out && !ext_mode;
				end
				default:      next_rdata = 8'h00;
			endcase
		end
	end

	// Registered outputs
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			IO_RDATA         <= 8'h00;
			INT_OSC_ON       <= 1'b1;
			EXT_OSC_ON       <= 1'b0;
			CLK_SEL_EXT      <= 1'b0;
			CORE_CLK_EN      <= 1'b0;
			LVR_ACTIVE       <= 1'b1;
			BOR_ACTIVE       <= 1'b0;
			OSC_IN_PULLDOWN  <= 1'b1;
			OSC_OUT_PIN_O    <= 1'b0;
			OSC_OUT_PIN_OE_N <= 1'b1;
			CPU_RESET        <= 1'b1;
			CPU_RUN          <= 1'b0;
			RESET_PC         <= RESET_VECTOR;
			PSP_RESET        <= STACK_RESET;
			DSP_RESET        <= STACK_RESET;
			NO_STACK_PUSH    <= 1'b1;
			PINS_HIZ         <= 1'b1;
			IRQ_DISABLE      <= 1'b1;
			USB_DISABLE      <= 1'b1;
		end else begin
			IO_RDATA         <= next_rdata;
			INT_OSC_ON       <= osc_int;
			EXT_OSC_ON       <= osc_ext;
			CLK_SEL_EXT      <= ext_mode && state != ST_OSC_START;
			CORE_CLK_EN      <= (next_state == ST_RUNNING);
			LVR_ACTIVE       <= lvr_enabled;
			BOR_ACTIVE       <= !lvr_enabled;
			OSC_IN_PULLDOWN  <= !ext_mode;
			OSC_OUT_PIN_O    <= drive_out && int_clk_div;
			OSC_OUT_PIN_OE_N <= !drive_out;
			CPU_RESET        <= (next_state != ST_RUNNING) && in_reset;
			CPU_RUN          <= (next_state == ST_RUNNING);
			RESET_PC         <= RESET_VECTOR;
			PSP_RESET        <= STACK_RESET;
			DSP_RESET        <= STACK_RESET;
			NO_STACK_PUSH    <= 1'b1;
			PINS_HIZ         <= in_reset;
			IRQ_DISABLE      <= in_reset;
			USB_DISABLE      <= in_reset;
		end
	end
endmodule : clock_reset_controller

// ### hdl/interval_timer.sv
// Purpose: Loadable down counter giving a done pulse
// Assumes: Load and tick come from the same clock
// Notes:   Load wins over counting
`timescale 1ns/10ps
module interval_timer #(
	parameter int WIDTH = 32
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] value,
	input  wire logic             run,
	output logic                  done
);
	logic [WIDTH-1:0] count;
	logic             next_done;

	assign next_done = run && !load && (count == {{(WIDTH-1){1'b0}}, 1'b1});

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			done  <= 1'b0;
		end else begin
			done <= next_done;
			if (load)
				count <= value;
			else if (run && count != '0)
				count <= count - 1'b1;
		end
	end
endmodule : interval_timer

// ### test/clock_reset_controller_assertions.sv
// Purpose: Port-level checks of the clock and reset sequencer
// Assumes: Single clock domain; RESETN low disables all checks
// Notes:   Attached by bind at the foot of this file
`timescale 1ns/10ps
module clock_reset_controller_assertions
	import clkrst_pkg::*;
(
	// Clock, reset and register port
	input wire logic        CLK,
	input wire logic        RESETN,
	input wire logic [7:0]  IO_ADDR,
	input wire logic        IO_RD,
	input wire logic [7:0]  IO_RDATA,
	// Monitors and oscillator control
	input wire logic        SUPPLY_ABOVE_LVR,
	input wire logic        INT_OSC_ON,
	input wire logic        EXT_OSC_ON,
	input wire logic        CLK_SEL_EXT,
	input wire logic        CORE_CLK_EN,
	input wire logic        LVR_ACTIVE,
	input wire logic        BOR_ACTIVE,
	// Processor controls
	input wire logic        CPU_RESET,
	input wire logic        CPU_RUN,
	input wire logic [15:0] RESET_PC,
	input wire logic [7:0]  PSP_RESET,
	input wire logic [7:0]  DSP_RESET,
	input wire logic        NO_STACK_PUSH,
	input wire logic        PINS_HIZ,
	input wire logic        IRQ_DISABLE,
	input wire logic        USB_DISABLE
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	a_reset_vector: assert property (RESET_PC == RESET_VECTOR && NO_STACK_PUSH)
		else $error("reset vector or push control wrong");
	a_stack_reset: assert property (PSP_RESET == STACK_RESET && DSP_RESET == STACK_RESET)
		else $error("stack pointer reset value wrong");
	a_reset_quiet: assert property (CPU_RESET |-> PINS_HIZ && IRQ_DISABLE && USB_DISABLE)
		else $error("pins or interrupts live during reset");
	a_gated_hold: assert property (CPU_RUN |-> CORE_CLK_EN && !CPU_RESET)
		else $error("processor runs while gated");
	a_ext_swap: assert property ($rose(EXT_OSC_ON) |-> !INT_OSC_ON && !CPU_RUN)
		else $error("oscillator swap without halt");
	a_wo_read: assert property (IO_RD && IO_ADDR == ADDR_WD_RESTART |=> IO_RDATA == 8'h00)
		else $error("restart register readable");
	a_bor_backup: assert property (!LVR_ACTIVE |-> BOR_ACTIVE)
		else $error("no supply monitor active");
	a_lvr_trip: assert property (LVR_ACTIVE && CPU_RUN && !SUPPLY_ABOVE_LVR
		|-> ##[1:6] (CPU_RESET && !CLK_SEL_EXT))
		else $error("supply trip did not reset to internal clock");
	a_int_running: assert property (CPU_RUN && !CLK_SEL_EXT |-> INT_OSC_ON)
		else $error("running on internal clock with oscillator off");
endmodule : clock_reset_controller_assertions

bind clock_reset_controller clock_reset_controller_assertions u_chk (
	.CLK(CLK), .RESETN(RESETN), .IO_ADDR(IO_ADDR), .IO_RD(IO_RD), .IO_RDATA(IO_RDATA),
	.SUPPLY_ABOVE_LVR(SUPPLY_ABOVE_LVR), .INT_OSC_ON(INT_OSC_ON), .EXT_OSC_ON(EXT_OSC_ON),
	.CLK_SEL_EXT(CLK_SEL_EXT), .CORE_CLK_EN(CORE_CLK_EN), .LVR_ACTIVE(LVR_ACTIVE),
	.BOR_ACTIVE(BOR_ACTIVE), .CPU_RESET(CPU_RESET), .CPU_RUN(CPU_RUN), .RESET_PC(RESET_PC),
	.PSP_RESET(PSP_RESET), .DSP_RESET(DSP_RESET), .NO_STACK_PUSH(NO_STACK_PUSH),
	.PINS_HIZ(PINS_HIZ), .IRQ_DISABLE(IRQ_DISABLE), .USB_DISABLE(USB_DISABLE)
);

// ### test/clock_reset_controller_tb.sv
// Purpose: Self-checking bench for the clock and reset sequencer
// Assumes: Shortened timing parameters; resonator model on the far side
// Notes:   Wake from suspend is covered in internal clock mode only
`timescale 1ns/10ps
module clock_reset_controller_tb;
	import clkrst_pkg::*;
	localparam int SD = 40, LD = 120, SU = 60, WD = 200, WR = 50, WK = 20, OS = 30;
	logic CLK = 0, RESETN = 0, IO_WR = 0, IO_RD = 0, SUPPLY_ABOVE_LVR = 0, SUPPLY_ABOVE_BOR = 0;
	logic [7:0] IO_ADDR = 8'h00, IO_WDATA = 8'h00, IO_RDATA, got;
	logic OSC_IN_PIN_I = 0, EXT_OSC_STABLE, INT_OSC_ON, EXT_OSC_ON, CLK_SEL_EXT, CORE_CLK_EN;
	logic LVR_ACTIVE, BOR_ACTIVE, OSC_IN_PULLDOWN, OSC_OUT_PIN_O, OSC_OUT_PIN_OE_N, CPU_RESET;
	logic CPU_RUN, NO_STACK_PUSH, PINS_HIZ, IRQ_DISABLE, USB_DISABLE, rd_seen = 0;
	logic OSC_OUT_PIN_I = 0, WAKE_EVENT = 0;
	logic [15:0] RESET_PC;
	logic [7:0] PSP_RESET, DSP_RESET;
	logic [7:0] expq[$];
	int mismatches = 0, checks_done = 0, n;

	always #4 CLK = ~CLK;

	clock_reset_controller #(.SHORT_DELAY(SD), .LONG_DELAY(LD), .STARTUP(SU), .WATCHDOG(WD),
		.WD_RESET(WR), .WAKE_DELAY(WK)) uut (
		.CLK(CLK), .RESETN(RESETN), .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA), .IO_WR(IO_WR),
		.IO_RD(IO_RD), .IO_RDATA(IO_RDATA), .WAKE_EVENT(WAKE_EVENT),
		.SUPPLY_ABOVE_LVR(SUPPLY_ABOVE_LVR), .SUPPLY_ABOVE_BOR(SUPPLY_ABOVE_BOR),
		.EXT_OSC_STABLE(EXT_OSC_STABLE), .INT_OSC_ON(INT_OSC_ON), .EXT_OSC_ON(EXT_OSC_ON),
		.CLK_SEL_EXT(CLK_SEL_EXT), .CORE_CLK_EN(CORE_CLK_EN), .LVR_ACTIVE(LVR_ACTIVE),
		.BOR_ACTIVE(BOR_ACTIVE), .OSC_IN_PIN_I(OSC_IN_PIN_I), .OSC_IN_PULLDOWN(OSC_IN_PULLDOWN),
		.OSC_OUT_PIN_I(OSC_OUT_PIN_I), .OSC_OUT_PIN_O(OSC_OUT_PIN_O),
		.OSC_OUT_PIN_OE_N(OSC_OUT_PIN_OE_N),
		.CPU_RESET(CPU_RESET), .CPU_RUN(CPU_RUN), .RESET_PC(RESET_PC), .PSP_RESET(PSP_RESET),
		.DSP_RESET(DSP_RESET), .NO_STACK_PUSH(NO_STACK_PUSH), .PINS_HIZ(PINS_HIZ),
		.IRQ_DISABLE(IRQ_DISABLE), .USB_DISABLE(USB_DISABLE)
	);

	ext_osc_model #(.START(OS)) osc (.clk(CLK), .osc_enable(EXT_OSC_ON), .osc_stable(EXT_OSC_STABLE));

	task automatic chk(input logic c, input string m);
		checks_done++;
		if (c !== 1'b1) begin
			mismatches++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge CLK);
		IO_ADDR = a;
		IO_RD = 1'b1;
		expq.push_back(e);
		@(negedge CLK);
		IO_RD = 1'b0;
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge CLK);
		IO_ADDR = a;
		IO_WDATA = d;
		IO_WR = 1'b1;
		@(negedge CLK);
		IO_WR = 1'b0;
	endtask : wr

	task automatic wait_run(input logic v, input int lim, output int cnt);
		cnt = 0;
		while (CPU_RUN !== v && cnt < lim) begin
			@(negedge CLK);
			cnt++;
		end
		chk(CPU_RUN === v, "run level not reached");
	endtask : wait_run

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	// Read data stands one cycle after the strobe edge
	always @(posedge CLK) rd_seen <= IO_RD;
	always @(negedge CLK) begin
		if (rd_seen) begin
			got = expq.pop_front();
			chk(IO_RDATA === got, "read data differs");
		end
	end

	initial begin
		#200000;
		mismatches++;
		$display("[ERR] %0t watchdog timeout", $time);
		finish_test();
	end

	initial begin
		void'($urandom(96));
		OSC_IN_PIN_I = 1'($urandom);
		OSC_OUT_PIN_I = 1'($urandom);
		repeat (8) @(negedge CLK);
		RESETN = 1'b1;
		repeat (20) @(negedge CLK);
		chk(CPU_RUN === 1'b0 && INT_OSC_ON === 1'b1, "ran before supply good");
		SUPPLY_ABOVE_LVR = 1'b1;
		SUPPLY_ABOVE_BOR = 1'b1;
		wait_run(1'b1, SU + 20, n);
		chk(n >= SU, "startup too short");
		rd(ADDR_STATUS, ST_POWERUP);
		rd(ADDR_CLK_CFG, CFG_RESET);
		rd(ADDR_WD_RESTART, 8'h00);
		rd(8'h77, 8'h00);
		rd(ADDR_PORT2, {5'h00, 1'b0, OSC_IN_PIN_I, 1'b0});
		chk(OSC_OUT_PIN_OE_N === 1'b0 && OSC_IN_PULLDOWN === 1'b1, "clock out idle");
		wr(ADDR_CLK_CFG, 8'h02);
		rd(ADDR_PORT2, {5'h00, OSC_OUT_PIN_I, OSC_IN_PIN_I, 1'b0});
		chk(OSC_OUT_PIN_OE_N === 1'b1 && OSC_OUT_PIN_O === 1'b0, "clock out not off");
		$display("test power_up done");
		wr(ADDR_CLK_CFG, 8'h01);
		repeat (3) @(negedge CLK);
		chk(EXT_OSC_ON === 1'b1 && INT_OSC_ON === 1'b0 && CPU_RUN === 1'b0, "no swap");
		chk(OSC_IN_PULLDOWN === 1'b0 && OSC_OUT_PIN_OE_N === 1'b1, "pins in ext mode");
		wait_run(1'b1, OS + SD + 40, n);
		chk(n >= OS + SD - 4, "resume delay short");
		chk(CLK_SEL_EXT === 1'b1, "external clock not selected");
		wr(ADDR_CLK_CFG, 8'h00);
		repeat (4) @(negedge CLK);
		chk(CLK_SEL_EXT === 1'b1, "left external clock early");
		wr(ADDR_CLK_CFG, 8'h01);
		$display("test ext_switch done");
		repeat (3) begin
			wr(ADDR_WD_RESTART, 8'($urandom));
			repeat ($urandom_range(150, 60)) @(negedge CLK);
			chk(CPU_RUN === 1'b1, "watchdog fired despite restart");
		end
		wait_run(1'b0, WD + 20, n);
		chk(CLK_SEL_EXT === 1'b1, "watchdog changed clock mode");
		wait_run(1'b1, WR + 20, n);
		chk(n >= WR - 2, "watchdog hold short");
		rd(ADDR_STATUS, ST_WATCHDOG);
		rd(ADDR_CLK_CFG, 8'h00);
		$display("test watchdog done");
		wr(ADDR_CLK_CFG, 8'h08);
		repeat (2) @(negedge CLK);
		chk(LVR_ACTIVE === 1'b0 && BOR_ACTIVE === 1'b1, "monitor swap");
		SUPPLY_ABOVE_LVR = 1'b0;
		repeat (6) @(negedge CLK);
		chk(CPU_RUN === 1'b1, "reset while low-voltage reset off");
		SUPPLY_ABOVE_BOR = 1'b0;
		repeat (6) @(negedge CLK);
		chk(CPU_RESET === 1'b1 && CLK_SEL_EXT === 1'b0 && EXT_OSC_ON === 1'b0, "trip");
		chk(LVR_ACTIVE === 1'b1, "brown-out left low-voltage reset off");
		SUPPLY_ABOVE_BOR = 1'b1;
		repeat (4) @(negedge CLK);
		chk(CPU_RESET === 1'b1, "released before supply good");
		SUPPLY_ABOVE_LVR = 1'b1;
		wait_run(1'b1, SU + 20, n);
		chk(n >= SU, "brown-out startup short");
		rd(ADDR_STATUS, ST_POWERUP);
		SUPPLY_ABOVE_LVR = 1'b0;
		repeat (6) @(negedge CLK);
		chk(CPU_RESET === 1'b1 && CPU_RUN === 1'b0, "low-voltage trip");
		SUPPLY_ABOVE_LVR = 1'b1;
		wait_run(1'b1, SU + 20, n);
		chk(n >= SU, "trip startup short");
		rd(ADDR_STATUS, ST_POWERUP);
		$display("test supply_trip done");
		wr(ADDR_STATUS, 8'h09);
		repeat (4) @(negedge CLK);
		chk(INT_OSC_ON === 1'b0 && EXT_OSC_ON === 1'b0 && CPU_RUN === 1'b0, "no suspend");
		chk(LVR_ACTIVE === 1'b0 && BOR_ACTIVE === 1'b1, "monitor in suspend");
		WAKE_EVENT = 1'b1;
		wait_run(1'b1, WK + 20, n);
		chk(n >= WK && CLK_SEL_EXT === 1'b0, "wake delay short");
		WAKE_EVENT = 1'b0;
		rd(ADDR_STATUS, 8'h01);
		$display("test suspend done");
		repeat (3) @(negedge CLK);
		finish_test();
	end
endmodule : clock_reset_controller_tb

// ### test/ext_osc_model.sv
// Purpose: External resonator that settles some cycles after power-on
// Assumes: Stability flag sampled by the design through its synchroniser
// Notes:   Flag drops on the first clock edge after the oscillator is switched off
`timescale 1ns/10ps
module ext_osc_model #(
	parameter int START = 30
) (
	// Clock
	input  wire logic clk,
	// Oscillator control and status
	input  wire logic osc_enable,
	output logic      osc_stable
);
	int count = 0;

	// Never stable before it has run its full start time
	always @(posedge clk) begin
		if (!osc_enable) begin
			count <= 0;
			osc_stable <= 1'b0;
		end else if (count < START) begin
			count <= count + 1;
		end else begin
			osc_stable <= 1'b1;
		end
	end
endmodule : ext_osc_model
